// ==== rtl/uobd_pkg.sv ====
package uobd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] OPT0_IDX = 8'h00;
  localparam logic [7:0] OPT1_IDX = 8'h01;
  localparam logic [7:0] STAT_IDX = 8'h02;
  localparam logic [7:0] OPT0_ADDR = {OPT0_IDX[5:0], 2'h0};
  localparam logic [7:0] OPT1_ADDR = {OPT1_IDX[5:0], 2'h0};
  localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'h0};

  // Flash locations of the two option bytes
  localparam logic [15:0] FLASH_OPT0 = 16'h0000;
  localparam logic [15:0] FLASH_OPT1 = 16'h0001;

  // Field positions, first option byte
  localparam int WDT_ACT_BIT = 7;
  localparam int WATCHDOG_ALWAYS_ON_BIT = 6;
  localparam int BO_AO_BIT = 3;
  localparam int RDP_BIT = 2;
  localparam int WRP_BIT = 0;
  // Field position, second option byte
  localparam int XTAL_BIT = 4;

  // Reserved bits, forced to one on write and read
  localparam logic [7:0] OPT0_RSVD = 8'h32;
  localparam logic [7:0] OPT1_RSVD = 8'hEF;
  localparam logic [7:0] ERASED = 8'hFF;

  // Status register fields
  localparam int ST_LOADED_BIT = 0;
  localparam int ST_WDT_RUN_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_REFUSED_BIT = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    ST_LOAD0 = 2'b00,
    ST_LOAD1 = 2'b01,
    ST_READY = 2'b10,
    ST_PROG = 2'b11
  } uobd_state_t;

  // Flash byte access request
  typedef struct packed {
    logic req;
    logic [15:0] addr;
    logic [7:0] data;
  } uobd_flash_req_t;

  // Decoded controls toward the consuming blocks
  typedef struct packed {
    logic ready;
    logic wdt_irq;
    logic wdt_sys_reset;
    logic wdt_run;
    logic brownout_on;
    logic code_read_ok;
    logic debug_full;
    logic user_flash_write_ok;
    logic debug_mass_erase_ok;
    logic xtal_on_in_reset;
    logic long_reset;
  } uobd_ctrl_t;
endpackage : uobd_pkg

// ==== rtl/uobd_top.sv ====
`timescale 1ns/10ps
// Function
// - Action bit 0: watchdog timeout raises an interrupt request.
// - Action bit 1, erased default: watchdog timeout forces a system reset.
// - Always-on bit 0: watchdog runs from power-up and cannot be disabled.
// - Always-on bit 1: watchdog starts on instruction; stops on reset or recovery.
// - First byte bits 5:4 reserved, written and read as 11.
// - Brown-out bit 0: off in stop mode only with power control bit set.
// - Brown-out bit 1, erased default: brown-out protection always on.
// - Read-protect 0: program code blocked, debugger limited.
// - Read-protect 1: code readable, every debugger command allowed.
// - Write-protect 0: user program and erase refused; debugger mass erase allowed.
// - Write-protect 1: program, page erase and mass erase permitted.
// - Crystal bit switches oscillator and reset length; clock selection stays separate.
// - Crystal bit 0: oscillator runs during reset, longer reset.
// - Crystal bit 1: oscillator off during reset, shorter reset.
// - Second byte bits 7:5 reserved, written and read as 111.
// - Second byte bits 3:0 reserved, written and read as 1111.
// - Option bits keep stored values through any reset.
// - Option bytes at flash 0000H/0001H, lost on page 0 erase.
module uobd_top (
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash read port
  output uobd_pkg::uobd_flash_req_t flash_rd,
  input wire logic flash_rd_ack,
  input wire logic [7:0] flash_rd_data,
  // Flash program port
  output uobd_pkg::uobd_flash_req_t flash_prog,
  input wire logic flash_prog_ack,
  input wire logic page0_erased,
  // Events from the consuming blocks
  input wire logic wdt_timeout,
  input wire logic watchdog_start_instruction,
  input wire logic stop_recovery,
  input wire logic stop_mode,
  input wire logic pwr_brownout_off,
  // Decoded controls
  output uobd_pkg::uobd_ctrl_t ctrl
);

  uobd_pkg::uobd_state_t state_reg;
  uobd_pkg::uobd_state_t state_next;
  logic [7:0] opt0_reg;
  logic [7:0] opt1_reg;
  logic wdt_run_reg;
  logic refused_reg;
  uobd_pkg::uobd_ctrl_t ctrl_reg;
  uobd_pkg::uobd_flash_req_t prog_reg;

  // AXI write and read side holding registers
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Option bytes as seen by everyone, reserved bits forced high
  wire [7:0] opt0_view = opt0_reg | uobd_pkg::OPT0_RSVD;
  wire [7:0] opt1_view = opt1_reg | uobd_pkg::OPT1_RSVD;
  wire loaded = (state_reg == uobd_pkg::ST_READY) || (state_reg == uobd_pkg::ST_PROG);
  wire act_bit = opt0_view[uobd_pkg::WDT_ACT_BIT];
  wire ao_bit = opt0_view[uobd_pkg::WATCHDOG_ALWAYS_ON_BIT];
  wire bo_bit = opt0_view[uobd_pkg::BO_AO_BIT];
  wire rdp_bit = opt0_view[uobd_pkg::RDP_BIT];
  wire wrp_bit = opt0_view[uobd_pkg::WRP_BIT];
  wire xtal_bit = opt1_view[uobd_pkg::XTAL_BIT];

  // Write address decode and acceptance
  wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg && (state_reg == uobd_pkg::ST_READY);
  wire wr_opt0 = (awaddr_reg == uobd_pkg::OPT0_ADDR);
  wire wr_opt1 = (awaddr_reg == uobd_pkg::OPT1_ADDR);
  wire wr_stat = (awaddr_reg == uobd_pkg::STAT_ADDR);
  wire wr_opt = wr_opt0 || wr_opt1;
  // Page 0 holds the option bytes, so write protect covers them too
  wire wr_allowed = wr_opt && wstrb0_reg && wrp_bit;
  wire wr_refused = wr_opt && !(wstrb0_reg && wrp_bit);
  wire [7:0] wr_byte = wr_opt0 ? (wdata_reg | uobd_pkg::OPT0_RSVD)
                               : (wdata_reg | uobd_pkg::OPT1_RSVD);
  wire [1:0] wr_resp = wr_refused ? uobd_pkg::RESP_SLVERR
                     : (wr_stat ? uobd_pkg::RESP_OKAY : uobd_pkg::RESP_DECERR);
  wire prog_done = (state_reg == uobd_pkg::ST_PROG) && flash_prog_ack;

  // Read decode
  wire rd_go = s_axi_arvalid && !rvalid_reg;
  wire rd_opt0 = (s_axi_araddr == uobd_pkg::OPT0_ADDR);
  wire rd_opt1 = (s_axi_araddr == uobd_pkg::OPT1_ADDR);
  wire rd_stat = (s_axi_araddr == uobd_pkg::STAT_ADDR);
  wire [7:0] stat_byte = {4'h0, refused_reg, (state_reg == uobd_pkg::ST_PROG),
                          wdt_run_reg, loaded};
  // Unmapped reads return zero beside the decode error
  wire [7:0] rd_byte = rd_opt0 ? opt0_view
                     : (rd_opt1 ? opt1_view : (rd_stat ? stat_byte : 8'h00));
  wire [1:0] rd_resp = (rd_opt0 || rd_opt1 || rd_stat) ? uobd_pkg::RESP_OKAY
                                                      : uobd_pkg::RESP_DECERR;

  // Handshake outputs
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Flash read requests: byte 0 then byte 1 after every reset
  assign flash_rd.req = (state_reg == uobd_pkg::ST_LOAD0) || (state_reg == uobd_pkg::ST_LOAD1);
  assign flash_rd.addr = (state_reg == uobd_pkg::ST_LOAD1) ? uobd_pkg::FLASH_OPT1
                                                           : uobd_pkg::FLASH_OPT0;
  assign flash_rd.data = 8'h00;
  assign flash_prog = prog_reg;
  assign ctrl = ctrl_reg;

  // Load sequence, then programming of option bytes on software writes
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      uobd_pkg::ST_LOAD0: begin
        if (flash_rd_ack) begin
          state_next = uobd_pkg::ST_LOAD1;
        end
      end
      uobd_pkg::ST_LOAD1: begin
        if (flash_rd_ack) begin
          state_next = uobd_pkg::ST_READY;
        end
      end
      uobd_pkg::ST_READY: begin
        if (wr_go && wr_allowed) begin
          state_next = uobd_pkg::ST_PROG;
        end
      end
      uobd_pkg::ST_PROG: begin
        if (flash_prog_ack) begin
          state_next = uobd_pkg::ST_READY;
        end
      end
      default: begin
        state_next = uobd_pkg::ST_LOAD0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= uobd_pkg::ST_LOAD0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Option byte latches; reset only to erased, true value reloaded from flash
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt0_reg <= uobd_pkg::ERASED;
      opt1_reg <= uobd_pkg::ERASED;
    end else if (page0_erased) begin
      opt0_reg <= uobd_pkg::ERASED;
      opt1_reg <= uobd_pkg::ERASED;
    end else if (flash_rd_ack && state_reg == uobd_pkg::ST_LOAD0) begin
      opt0_reg <= flash_rd_data;
    end else if (flash_rd_ack && state_reg == uobd_pkg::ST_LOAD1) begin
      opt1_reg <= flash_rd_data;
    end else if (prog_done && prog_reg.addr == uobd_pkg::FLASH_OPT0) begin
      opt0_reg <= prog_reg.data;
    end else if (prog_done) begin
      opt1_reg <= prog_reg.data;
    end
  end

  // Program request held until the flash takes it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_reg <= '0;
    end else if (wr_go && wr_allowed) begin
      prog_reg.req <= 1'b1;
      prog_reg.addr <= wr_opt0 ? uobd_pkg::FLASH_OPT0 : uobd_pkg::FLASH_OPT1;
      prog_reg.data <= wr_byte;
    end else if (prog_done) begin
      prog_reg.req <= 1'b0;
    end
  end

  // Watchdog run state; always-on wins over any stop
  wire wdt_run_next = (loaded && !ao_bit)
                    || (loaded && watchdog_start_instruction)
                    || (wdt_run_reg && !stop_recovery);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_run_reg <= 1'b0;
    end else begin
      wdt_run_reg <= wdt_run_next;
    end
  end

  // Decoded controls, registered so consumers see one clean set
  wire wdt_fire = loaded && wdt_run_reg && wdt_timeout;
  uobd_pkg::uobd_ctrl_t ctrl_next;
  always_comb begin
    ctrl_next.ready = loaded;
    ctrl_next.wdt_irq = wdt_fire && !act_bit;
    ctrl_next.wdt_sys_reset = wdt_fire && act_bit;
    ctrl_next.wdt_run = wdt_run_reg;
    // Stop-mode switch-off needs both the option and the power control bit
    ctrl_next.brownout_on = bo_bit || !(stop_mode && pwr_brownout_off);
    ctrl_next.code_read_ok = loaded && rdp_bit;
    ctrl_next.debug_full = loaded && rdp_bit;
    ctrl_next.user_flash_write_ok = loaded && wrp_bit;
    ctrl_next.debug_mass_erase_ok = 1'b1;
    // Oscillator enable and reset length only; clock source choice is elsewhere
    ctrl_next.xtal_on_in_reset = !xtal_bit;
    ctrl_next.long_reset = !xtal_bit;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Write channels taken in either order, held until the response
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_held_reg <= 1'b0;
    end
  end

  // Response: at once for refusals, after the flash ack for programming
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= uobd_pkg::RESP_OKAY;
    end else if (wr_go && !wr_allowed) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_resp;
    end else if (prog_done) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= uobd_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Sticky refusal flag; a new refusal wins over the clear by status write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_reg <= 1'b0;
    end else if (wr_go && wr_refused) begin
      refused_reg <= 1'b1;
    end else if (wr_go && wr_stat && wdata_reg[uobd_pkg::ST_REFUSED_BIT]) begin
      refused_reg <= 1'b0;
    end
  end

  // Read channel, one cycle answer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= uobd_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks on the block's own behaviour
  a_wdt_irq_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wdt_fire && !act_bit) |=> (ctrl.wdt_irq && !ctrl.wdt_sys_reset))
    else $error("timeout with action 0 did not raise irq");
  a_wdt_reset_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wdt_fire && act_bit) |=> (ctrl.wdt_sys_reset && !ctrl.wdt_irq))
    else $error("timeout with action 1 did not reset");
  a_wdt_always_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    (loaded && !ao_bit) |-> ##2 ctrl.wdt_run)
    else $error("always-on watchdog not running");
  a_wdt_start_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ao_bit && $stable(opt0_reg) && !wdt_run_reg && !watchdog_start_instruction)
      |=> !wdt_run_reg)
    else $error("watchdog started without instruction");
  a_rsvd_reads: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rvalid_reg && $rose(rvalid_reg) && $past(rd_opt0)) |-> (rdata_reg[5:4] == 2'h3))
    else $error("reserved bits 5:4 not read as 11");
  a_brownout_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    bo_bit |=> ctrl.brownout_on)
    else $error("brown-out dropped while always-on");
  a_brownout_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!bo_bit && stop_mode && pwr_brownout_off) |=> !ctrl.brownout_on)
    else $error("brown-out not switched off in stop");
  a_read_protect: assert property (@(posedge core_clk) disable iff (!rst_n)
    (loaded && !rdp_bit) |=> (!ctrl.code_read_ok && !ctrl.debug_full))
    else $error("code readable while read protected");
  a_write_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_go && wr_opt && !wrp_bit) |=> (s_axi_bvalid && s_axi_bresp == uobd_pkg::RESP_SLVERR
      && !flash_prog.req))
    else $error("protected option write not refused");
  a_load_order: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_reg == uobd_pkg::ST_LOAD1 && flash_rd_ack) |=> ##1 ctrl.ready)
    else $error("controls not released after load");
  a_xtal_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!xtal_bit && $stable(opt1_reg)) |=> (ctrl.xtal_on_in_reset && ctrl.long_reset))
    else $error("crystal not enabled in reset");

endmodule : uobd_top

// ==== testbench/uobd_flash_model.sv ====
`timescale 1ns/10ps
// Option flash: answers reads and programs after a wait chosen by the bench
module uobd_flash_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] delay,
  input wire uobd_pkg::uobd_flash_req_t flash_rd,
  output logic flash_rd_ack,
  output logic [7:0] flash_rd_data,
  input wire uobd_pkg::uobd_flash_req_t flash_prog,
  output logic flash_prog_ack
);
  logic [7:0] mem [2];
  int cnt;
  logic hit_rd, hit_prog;

  // Only the first two program locations hold option bytes
  assign hit_rd = flash_rd.addr[15:1] == 15'h0;
  assign hit_prog = flash_prog.addr[15:1] == 15'h0;

  // The array is left alone on reset, as nonvolatile cells are
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_rd_ack <= 1'b0;
      flash_prog_ack <= 1'b0;
      flash_rd_data <= 8'hA5;
      cnt <= 0;
    end else if (flash_rd_ack || flash_prog_ack) begin
      flash_rd_ack <= 1'b0;
      flash_prog_ack <= 1'b0;
      flash_rd_data <= ~flash_rd_data; // Stale byte must not look valid
      cnt <= 0;
    end else if (flash_rd.req || flash_prog.req) begin
      if (cnt < int'(delay)) begin
        cnt <= cnt + 1;
      end else if (flash_prog.req) begin
        if (hit_prog) mem[flash_prog.addr[0]] <= flash_prog.data;
        flash_prog_ack <= 1'b1;
      end else begin
        flash_rd_data <= hit_rd ? mem[flash_rd.addr[0]] : 8'h00;
        flash_rd_ack <= 1'b1;
      end
    end
  end
endmodule : uobd_flash_model

// ==== testbench/test_user_option_byte_decode.sv ====
`timescale 1ns/10ps
// Random option bytes go into flash; decoded controls and register views are checked
module test_user_option_byte_decode;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, flash_rd_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic flash_rd_ack, flash_prog_ack, page0_erased, wdt_timeout, watchdog_start_instruction;
  logic stop_recovery, stop_mode, pwr_brownout_off;
  logic [2:0] delay;
  uobd_pkg::uobd_flash_req_t flash_rd, flash_prog;
  uobd_pkg::uobd_ctrl_t ctrl;
  int failures = 0;
  int checks_done = 0;
  int exp_opt [2];

  uobd_top uut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_rd, .flash_rd_ack, .flash_rd_data,
    .flash_prog, .flash_prog_ack, .page0_erased, .wdt_timeout, .watchdog_start_instruction,
    .stop_recovery, .stop_mode, .pwr_brownout_off, .ctrl);

  uobd_flash_model flash (.core_clk, .rst_n, .delay, .flash_rd, .flash_rd_ack,
    .flash_rd_data, .flash_prog, .flash_prog_ack);

  // Clock and hang guard at 40000 cycles; the run needs only about a thousand cycles
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    failures++;
    give_verdict();
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // Caller stands on a rising edge; reset holds for 12 cycles
  task automatic do_reset();
    int n;
    n = 0;
    rst_n <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (!ctrl.ready && n < 500);
    check("load done", n < 500, 1);
  endtask : do_reset

  // Both channels offered at once, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 3000);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    check("write answered", n < 3000, 1);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 3000);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check("read answered", n < 3000, 1);
  endtask : axi_read

  // Main sequence: eight flash images cover every option setting
  initial begin
    logic [7:0] b0, b1, nv, ad;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] s;
    logic refused;
    int k, irq_n, sr_n;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {page0_erased, wdt_timeout, watchdog_start_instruction, stop_recovery} = '0;
    {stop_mode, pwr_brownout_off, delay} = '0;
    rst_n = 1'b0;
    void'($urandom(5112));
    for (int i = 0; i < 8; i++) begin
      b0 = 8'($urandom);
      b1 = 8'($urandom);
      b0[0] = i[0];
      b0[6] = i[1];
      b0[7] = i[0] ^ i[1];
      b0[3] = i[2];
      b0[2] = i[1] ^ i[2];
      b1[4] = i[0];
      flash.mem[0] = b0;
      flash.mem[1] = b1;
      exp_opt[0] = {24'h0, b0 | uobd_pkg::OPT0_RSVD};
      exp_opt[1] = {24'h0, b1 | uobd_pkg::OPT1_RSVD};
      delay <= 3'($urandom);
      // Odd images force the stop-mode switch-off request so it is always reached
      stop_mode <= 1'($urandom) | i[0];
      pwr_brownout_off <= 1'($urandom) | i[0];
      do_reset();
      repeat (2) @(posedge core_clk);
      #1;
      check("code_read_ok", ctrl.code_read_ok, b0[2]);
      check("debug_full", ctrl.debug_full, b0[2]);
      check("user_write_ok", ctrl.user_flash_write_ok, b0[0]);
      check("debug_erase_ok", ctrl.debug_mass_erase_ok, 1);
      check("xtal_on", ctrl.xtal_on_in_reset, !b1[4]);
      check("long_reset", ctrl.long_reset, !b1[4]);
      check("brownout_on", ctrl.brownout_on, b0[3] | !(stop_mode & pwr_brownout_off));
      check("wdt_run", ctrl.wdt_run, !b0[6]);
      for (k = 0; k < 2; k++) begin
        axi_read(k ? uobd_pkg::OPT1_ADDR : uobd_pkg::OPT0_ADDR, d, r);
        check("option view", d, exp_opt[k]);
      end
      // Watchdog: start by instruction when not always on, then a timeout
      if (b0[6]) begin
        @(posedge core_clk);
        watchdog_start_instruction <= 1'b1;
        @(posedge core_clk);
        watchdog_start_instruction <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check("wdt started", ctrl.wdt_run, 1);
      end
      @(posedge core_clk);
      wdt_timeout <= 1'b1;
      irq_n = 0;
      sr_n = 0;
      @(posedge core_clk);
      wdt_timeout <= 1'b0;
      repeat (3) begin
        #1;
        irq_n += ctrl.wdt_irq;
        sr_n += ctrl.wdt_sys_reset;
        @(posedge core_clk);
      end
      check("timeout irq", irq_n, !b0[7]);
      check("timeout reset", sr_n, b0[7]);
      stop_recovery <= 1'b1;
      @(posedge core_clk);
      stop_recovery <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check("wdt after recovery", ctrl.wdt_run, !b0[6]);
      // Write: reserved bits sent as ones; refused under write protect
      k = i[2];
      nv = 8'($urandom) | (k ? 8'hEF : 8'h32);
      s = (i == 5) ? 4'hE : 4'hF;
      refused = !b0[0] || !s[0];
      ad = k ? uobd_pkg::OPT1_ADDR : uobd_pkg::OPT0_ADDR;
      axi_write(ad, {24'($urandom), nv}, s, r);
      check("write resp", r, refused ? uobd_pkg::RESP_SLVERR : uobd_pkg::RESP_OKAY);
      if (!refused) exp_opt[k] = {24'h0, nv};
      axi_read(uobd_pkg::STAT_ADDR, d, r);
      check("status", d & 32'h9, {refused, 3'b001});
      // Writing one to the refusal flag clears it; unmapped writes are decode errors
      axi_write(uobd_pkg::STAT_ADDR, 32'h8, 4'hF, r);
      check("status clear resp", r, uobd_pkg::RESP_OKAY);
      axi_read(uobd_pkg::STAT_ADDR, d, r);
      check("status cleared", d & 32'h9, 32'h1);
      axi_write(8'h0C, 32'h0, 4'hF, r);
      check("unmapped write", r, uobd_pkg::RESP_DECERR);
      axi_read(8'h0C, d, r);
      check("unmapped", {r, d}, {uobd_pkg::RESP_DECERR, 32'h0});
      do_reset();
      axi_read(ad, d, r);
      check("kept over reset", d, exp_opt[k]);
    end
    // Page 0 erase loses both bytes
    @(posedge core_clk);
    page0_erased <= 1'b1;
    flash.mem[0] = 8'hFF;
    flash.mem[1] = 8'hFF;
    @(posedge core_clk);
    page0_erased <= 1'b0;
    for (int j = 0; j < 2; j++) begin
      axi_read(j ? uobd_pkg::OPT1_ADDR : uobd_pkg::OPT0_ADDR, d, r);
      check("erased view", d, 32'hFF);
    end
    give_verdict();
  end
endmodule : test_user_option_byte_decode
